// *** logic/sleep_gate_params.svh ***
`ifndef SLEEP_GATE_PARAMS_SVH
`define SLEEP_GATE_PARAMS_SVH

// ============================================================
// Register offsets (byte addresses)
`define OFS_RUN_CFG     12'h060
`define OFS_RUN_GATE    12'h100
`define OFS_SLEEP_GATE  12'h110
`define OFS_DEEP_GATE   12'h120
`define OFS_EVT_STATUS  12'h130
`define OFS_EVT_MASK    12'h134

// ============================================================
// Gating register layout, shared by run, sleep and deep sleep
`define GATE_RESET      32'h0000_0040
`define GATE_WR_MASK    32'h0011_0348
`define BIT_PWM         20
`define BIT_ADC         16
`define RATE_MSB        9
`define RATE_LSB        8
`define BIT_HIB         6
`define BIT_WDT         3
`define RATE_MAX        2'h2

// ============================================================
// Run clock configuration layout
`define CFG_RESET       32'h0000_0000
`define CFG_WR_MASK     32'h0800_0000
`define BIT_AUTO_GATE   27

// ============================================================
// Fault events: pwm, converter, watchdog
`define EVT_W           3
`define EVT_PWM         0
`define EVT_ADC         1
`define EVT_WDT         2
`define EVT_RESET       3'h0

// ============================================================
// Avalon response codes
`define RESP_OKAY       2'h0
`define RESP_DECERR     2'h3

`endif

// *** logic/sleep_gate_pkg.sv ***
package sleep_gate_pkg;

   typedef enum logic [1:0]
   {
      mode_run   = 2'b00,
      mode_sleep = 2'b01,
      mode_deep  = 2'b10
   } power_mode_type;

   typedef enum logic
   {
      bus_idle = 1'b0,
      bus_ack  = 1'b1
   } bus_state_type;

endpackage : sleep_gate_pkg

// *** logic/gate_reg.sv ***
`timescale 1ns/1ps
`include "sleep_gate_params.svh"

module gate_reg #(
   parameter logic [31:0] RESET_VALUE = `GATE_RESET,
   parameter logic [31:0] WR_MASK     = `GATE_WR_MASK,
   parameter bit          HAS_RATE    = 1'b1,
   parameter logic [1:0]  RATE_MAX    = `RATE_MAX
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic [31:0] lane_mask,
   output logic      [31:0] value
);

   logic [31:0] next_value;
   logic [31:0] keep;
   logic [1:0]  rate;

   // ============================================================
   // Write with lane and layout masks
   always_comb
   begin
      keep       = WR_MASK & lane_mask;
      next_value = value;
      rate       = 2'h0;
      if (wr_en)
      begin
         next_value = (value & ~keep) | (wr_data & keep);
         rate = next_value[`RATE_MSB:`RATE_LSB];
         if (HAS_RATE && rate > RATE_MAX)
         begin
            // Rate above the maximum is held at the maximum
            next_value[`RATE_MSB:`RATE_LSB] = RATE_MAX;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         value <= RESET_VALUE;
      else
         value <= next_value;
   end

endmodule : gate_reg

// *** logic/event_status.sv ***
`timescale 1ns/1ps
`include "sleep_gate_params.svh"

module event_status #(
   parameter int W = `EVT_W
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] event_in,
   input  wire logic         clr_en,
   input  wire logic [W-1:0] clr_data,
   input  wire logic         mask_en,
   input  wire logic [W-1:0] mask_data,
   output logic      [W-1:0] status,
   output logic      [W-1:0] mask,
   output logic              irq
);

   logic [W-1:0] next_status;
   logic [W-1:0] next_mask;
   logic         next_irq;

   // ============================================================
   // Sticky status, write one to clear, set beats clear
   always_comb
   begin
      next_status = status;
      if (clr_en)
         next_status = status & ~clr_data;
      next_status = next_status | event_in;
      next_mask   = mask_en ? mask_data : mask;
      next_irq    = |(next_status & next_mask);
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end
      else
      begin
         status <= next_status;
         mask   <= next_mask;
         irq    <= next_irq;
      end
   end

endmodule : event_status

// *** logic/sleep_mode_clock_gating.sv ***
// Notes on behaviour
// - Each writable gate bit except the rate bits 9:8 is the clock enable of one unit.
// - An access to the pwm, converter or watchdog unit while its clock is gated off raises a unit fault.
// - The sleep gating register sits at 0x110 and resets to 0x00000040.
// - The run register applies in run mode; sleep and deep-sleep registers apply in their own mode only with automatic gating.
// - Sleep settings apply only while automatic gating is selected.
// - Bit 20 gates the pulse-width modulator; accesses fault when clear.
// - Bit 16 gates the converter; accesses fault when clear.
// - Bits 9:8 set the converter rate, never above the supported maximum.
// - Bit 6 gates the hibernation unit.
// - Bit 3 gates the watchdog; accesses fault when clear.
// - Reserved bits are read-only and read as zero.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sleep_gate_params.svh"

module sleep_mode_clock_gating #(
   parameter logic [1:0] RATE_MAX = `RATE_MAX
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic      [1:0]  avs_response,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  power_mode,
   input  wire logic [2:0]  unit_access,
   output logic      [3:0]  unit_clk_en,
   output logic      [1:0]  converter_rate_limit,
   output logic      [2:0]  unit_fault,
   output logic             irq
);

   // ============================================================
   // Bus slave state
   sleep_gate_pkg::bus_state_type bus_state;
   sleep_gate_pkg::bus_state_type next_bus_state;
   logic [31:0] next_readdata;
   logic [1:0]  next_response;
   logic        next_waitrequest;
   logic        req;
   logic        accept_wr;
   logic [31:0] lane_mask;
   logic [31:0] read_mux;
   logic        hit;

   // ============================================================
   // Register values
   logic [31:0] run_cfg;
   logic [31:0] next_run_cfg;
   logic [31:0] run_gate;
   logic [31:0] sleep_gate;
   logic [31:0] deep_gate;
   logic [`EVT_W-1:0] evt_status;
   logic [`EVT_W-1:0] evt_mask;
   logic        irq_level;

   // ============================================================
   // Gating outputs
   sleep_gate_pkg::power_mode_type mode;
   logic [31:0] active_gate;
   logic [3:0]  next_unit_clk_en;
   logic [1:0]  next_rate;
   logic [2:0]  next_unit_fault;
   logic [2:0]  fault_event;
   logic        auto_gate;

   assign req       = avs_read | avs_write;
   assign accept_wr = avs_write & ~avs_waitrequest;

   // ============================================================
   // Byte lane expansion
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         lane_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
      end
   end

   // ============================================================
   // Read decode
   always_comb
   begin
      hit      = 1'b1;
      read_mux = 32'h0000_0000;
      unique case (avs_address)
         `OFS_RUN_CFG:    read_mux = run_cfg;
         `OFS_RUN_GATE:   read_mux = run_gate;
         `OFS_SLEEP_GATE: read_mux = sleep_gate;
         `OFS_DEEP_GATE:  read_mux = deep_gate;
         `OFS_EVT_STATUS: read_mux[`EVT_W-1:0] = evt_status;
         `OFS_EVT_MASK:   read_mux[`EVT_W-1:0] = evt_mask;
         default:         hit = 1'b0;
      endcase
   end

   // ============================================================
   // Avalon handshake: one wait cycle, then one cycle low
   always_comb
   begin
      next_bus_state   = bus_state;
      next_waitrequest = 1'b1;
      next_readdata    = avs_readdata;
      next_response    = avs_response;
      unique case (bus_state)
         sleep_gate_pkg::bus_idle:
         begin
            if (req)
            begin
               next_bus_state   = sleep_gate_pkg::bus_ack;
               next_waitrequest = 1'b0;
               next_readdata    = avs_read ? read_mux : 32'h0000_0000;
               next_response    = hit ? `RESP_OKAY : `RESP_DECERR;
            end
         end
         sleep_gate_pkg::bus_ack:
         begin
            next_bus_state = sleep_gate_pkg::bus_idle;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bus_state       <= sleep_gate_pkg::bus_idle;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         avs_response    <= `RESP_OKAY;
      end
      else
      begin
         bus_state       <= next_bus_state;
         avs_waitrequest <= next_waitrequest;
         avs_readdata    <= next_readdata;
         avs_response    <= next_response;
      end
   end

   // ============================================================
   // Run clock configuration (automatic gating select)
   always_comb
   begin
      next_run_cfg = run_cfg;
      if (accept_wr && avs_address == `OFS_RUN_CFG)
      begin
         next_run_cfg = (run_cfg & ~(`CFG_WR_MASK & lane_mask))
                      | (avs_writedata & `CFG_WR_MASK & lane_mask);
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         run_cfg <= `CFG_RESET;
      else
         run_cfg <= next_run_cfg;
   end

   assign auto_gate = run_cfg[`BIT_AUTO_GATE];

   // ============================================================
   // Gating registers, one layout for all three modes
   gate_reg #(
      .RESET_VALUE (`GATE_RESET),
      .WR_MASK     (`GATE_WR_MASK),
      .HAS_RATE    (1'b1),
      .RATE_MAX    (RATE_MAX)
   ) u_run_gate (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .wr_en     (accept_wr && avs_address == `OFS_RUN_GATE),
      .wr_data   (avs_writedata),
      .lane_mask (lane_mask),
      .value     (run_gate)
   );

   gate_reg #(
      .RESET_VALUE (`GATE_RESET),
      .WR_MASK     (`GATE_WR_MASK),
      .HAS_RATE    (1'b1),
      .RATE_MAX    (RATE_MAX)
   ) u_sleep_gate (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .wr_en     (accept_wr && avs_address == `OFS_SLEEP_GATE),
      .wr_data   (avs_writedata),
      .lane_mask (lane_mask),
      .value     (sleep_gate)
   );

   gate_reg #(
      .RESET_VALUE (`GATE_RESET),
      .WR_MASK     (`GATE_WR_MASK),
      .HAS_RATE    (1'b1),
      .RATE_MAX    (RATE_MAX)
   ) u_deep_gate (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .wr_en     (accept_wr && avs_address == `OFS_DEEP_GATE),
      .wr_data   (avs_writedata),
      .lane_mask (lane_mask),
      .value     (deep_gate)
   );

   // ============================================================
   // Mode selection of the active gating register
   always_comb
   begin
      mode        = sleep_gate_pkg::power_mode_type'(power_mode);
      active_gate = run_gate;
      unique case (mode)
         sleep_gate_pkg::mode_run:
            active_gate = run_gate;
         sleep_gate_pkg::mode_sleep:
            active_gate = auto_gate ? sleep_gate : run_gate;
         sleep_gate_pkg::mode_deep:
            active_gate = auto_gate ? deep_gate : run_gate;
         default:
            active_gate = run_gate;
      endcase
   end

   // ============================================================
   // Clock enables, rate and access faults
   always_comb
   begin
      next_unit_clk_en[3] = active_gate[`BIT_PWM];
      next_unit_clk_en[2] = active_gate[`BIT_ADC];
      next_unit_clk_en[1] = active_gate[`BIT_HIB];
      next_unit_clk_en[0] = active_gate[`BIT_WDT];
      next_rate = active_gate[`RATE_MSB:`RATE_LSB];
      fault_event[`EVT_PWM] =
         unit_access[`EVT_PWM] & ~unit_clk_en[3];
      fault_event[`EVT_ADC] =
         unit_access[`EVT_ADC] & ~unit_clk_en[2];
      fault_event[`EVT_WDT] =
         unit_access[`EVT_WDT] & ~unit_clk_en[0];
      next_unit_fault = fault_event;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         unit_clk_en          <= 4'h0;
         converter_rate_limit <= 2'h0;
         unit_fault           <= 3'h0;
      end
      else
      begin
         unit_clk_en          <= next_unit_clk_en;
         converter_rate_limit <= next_rate;
         unit_fault           <= next_unit_fault;
      end
   end

   // ============================================================
   // Fault status and interrupt
   event_status #(
      .W (`EVT_W)
   ) u_events (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .event_in  (fault_event),
      .clr_en    (accept_wr && avs_address == `OFS_EVT_STATUS
                  && avs_byteenable[0]),
      .clr_data  (avs_writedata[`EVT_W-1:0]),
      .mask_en   (accept_wr && avs_address == `OFS_EVT_MASK
                  && avs_byteenable[0]),
      .mask_data (avs_writedata[`EVT_W-1:0]),
      .status    (evt_status),
      .mask      (evt_mask),
      .irq       (irq_level)
   );

   assign irq = irq_level;

endmodule : sleep_mode_clock_gating

// *** testbench/sleep_gate_asserts.sv ***
`timescale 1ns/1ps
module sleep_gate_asserts #(
   parameter logic [1:0] RATE_MAX = 2'h2
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic [1:0]  avs_response,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  power_mode,
   input wire logic [2:0]  unit_access,
   input wire logic [3:0]  unit_clk_en,
   input wire logic [1:0]  converter_rate_limit,
   input wire logic [2:0]  unit_fault,
   input wire logic        irq
);
   // ==========
   // Cycles since reset, saturating
   logic [1:0] up;
   logic [1:0] next_up;
   logic       mapped;
   always_comb next_up = (up == 2'h3) ? up : up + 2'h1;
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         up <= 2'h0;
      else
         up <= next_up;
   assign mapped = avs_address inside {12'h060, 12'h100, 12'h110,
                                       12'h120, 12'h130, 12'h134};
   // ==========
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence acked;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   wait_ack_a: assert property (taken |=> acked)
      else $error("request not answered in one cycle");
   ack_cause_a: assert property ($fell(avs_waitrequest) |->
      $past(avs_read || avs_write)) else $error("ack without request");
   unmapped_a: assert property (taken ##0 (avs_read && !mapped) |=>
      avs_response == 2'h3 && avs_readdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   pwm_fault_a: assert property (unit_access[0] && !unit_clk_en[3]
      |=> unit_fault[0]) else $error("pwm fault missing");
   wdt_fault_a: assert property (unit_access[2] && !unit_clk_en[0]
      |=> unit_fault[2]) else $error("watchdog fault missing");
   adc_fault_a: assert property (unit_fault[1] |->
      $past(unit_access[1] && !unit_clk_en[2]))
      else $error("converter fault without cause");
   rate_cap_a: assert property (converter_rate_limit <= RATE_MAX)
      else $error("rate above maximum");
   en_cause_a: assert property (up == 2'h3 && $changed(unit_clk_en)
      |-> $past(avs_write && !avs_waitrequest, 2)
      || $past(power_mode) != $past(power_mode, 2))
      else $error("enable changed without cause");
endmodule : sleep_gate_asserts

bind sleep_mode_clock_gating sleep_gate_asserts #(.RATE_MAX(RATE_MAX)) chk (
   .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_response, .avs_waitrequest,
   .power_mode, .unit_access, .unit_clk_en, .converter_rate_limit,
   .unit_fault, .irq);

// *** testbench/unit_model.sv ***
`timescale 1ns/1ps
module unit_model (
   input  wire logic       clk,
   output logic      [2:0] unit_access
);
   initial unit_access = 3'h0;
   // One-cycle access to each selected unit
   task automatic touch(input logic [2:0] which);
      @(posedge clk);
      unit_access <= which;
      @(posedge clk);
      unit_access <= 3'h0;
   endtask : touch
endmodule : unit_model

// *** testbench/sleep_mode_clock_gating_tb.sv ***
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb;
   logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, irq;
   logic [11:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable, unit_clk_en;
   logic [1:0]  avs_response, power_mode, converter_rate_limit, rsp;
   logic [2:0]  unit_access, unit_fault;
   int          n_errors = 0;
   int          n_tests = 0;

   initial clk = 1'b0;
   always #4 clk = ~clk;

   sleep_mode_clock_gating dut (.clk, .sys_rst, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
      .avs_response, .avs_waitrequest, .power_mode, .unit_access,
      .unit_clk_en, .converter_rate_limit, .unit_fault, .irq);
   unit_model um (.clk, .unit_access);

   // ==========
   // Bus and compare tasks
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge clk);
      // Only the watchdog ends a wait that never sees an answer
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      rd = avs_readdata;
      rsp = avs_response;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t bits %h expected %h", $time, got, exp);
      end
   endtask : chk_bits
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk_word(rd, exp);
   endtask : rdc
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask : settle
   task automatic mode(input logic [1:0] m);
      @(posedge clk);
      power_mode <= m;
      settle;
   endtask : mode
   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask : end_test
   task automatic finish_test;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (3000) @(posedge clk);
      n_errors++;
      finish_test;
   end

   // ==========
   // Tests
   initial
   begin
      sys_rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 12'h000;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      power_mode = 2'h0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(12'h110, 32'h0000_0040);
      rdc(12'h100, 32'h0000_0040);
      chk_bits(unit_clk_en, 4'h2);
      end_test("reset");
      bus(1'b1, 12'h110, 32'hffff_ffff);
      rdc(12'h110, 32'h0011_0248);
      bus(1'b1, 12'h110, 32'h0000_0100);
      rdc(12'h110, 32'h0000_0100);
      avs_byteenable <= 4'h1;
      bus(1'b1, 12'h110, 32'hffff_ffff);
      avs_byteenable <= 4'hf;
      rdc(12'h110, 32'h0000_0148);
      rdc(12'h200, 32'h0000_0000);
      chk_bits({2'h0, rsp}, 4'h3);
      end_test("fields");
      um.touch(3'h7);
      @(negedge clk);
      chk_bits({1'b0, unit_fault}, 4'h7);
      rdc(12'h130, 32'h0000_0007);
      chk_bits({3'h0, irq}, 4'h0);
      bus(1'b1, 12'h134, 32'h0000_0007);
      settle;
      chk_bits({3'h0, irq}, 4'h1);
      bus(1'b1, 12'h130, 32'h0000_0007);
      settle;
      chk_bits({3'h0, irq}, 4'h0);
      end_test("fault");
      bus(1'b1, 12'h100, 32'h0011_0248);
      settle;
      chk_bits(unit_clk_en, 4'hf);
      chk_bits({2'h0, converter_rate_limit}, 4'h2);
      um.touch(3'h7);
      @(negedge clk);
      chk_bits({1'b0, unit_fault}, 4'h0);
      end_test("enable");
      bus(1'b1, 12'h110, 32'h0000_0108);
      bus(1'b1, 12'h120, 32'h0001_0000);
      mode(2'h1);
      chk_bits(unit_clk_en, 4'hf);
      bus(1'b1, 12'h060, 32'h0800_0000);
      settle;
      chk_bits(unit_clk_en, 4'h1);
      chk_bits({2'h0, converter_rate_limit}, 4'h1);
      um.touch(3'h7);
      @(negedge clk);
      chk_bits({1'b0, unit_fault}, 4'h3);
      mode(2'h2);
      chk_bits(unit_clk_en, 4'h4);
      mode(2'h0);
      chk_bits(unit_clk_en, 4'hf);
      end_test("modes");
      finish_test;
   end
endmodule : sleep_mode_clock_gating_tb
